// ===== rtl/ddrpi_params.svh
`ifndef DDRPI_PARAMS_SVH
`define DDRPI_PARAMS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define DDRPI_ADDR_W 14
`define DDRPI_DATA_W 16
`define DDRPI_BANKS 4

// ----------------------------------------------------------------
// Field positions and selector values
// ----------------------------------------------------------------
`define DDRPI_SCOPE_BIT 10
`define DDRPI_MODE_SEL_BASE 2'h0
`define DDRPI_MODE_SEL_EXT 2'h1

// ----------------------------------------------------------------
// Command codes on {row, column, write-enable} strobes
// ----------------------------------------------------------------
`define DDRPI_CMD_LOAD_MODE 3'h0
`define DDRPI_CMD_REFRESH 3'h1
`define DDRPI_CMD_PRECHARGE 3'h2
`define DDRPI_CMD_ACTIVATE 3'h3
`define DDRPI_CMD_WRITE 3'h4
`define DDRPI_CMD_READ 3'h5
`define DDRPI_CMD_BURST_STOP 3'h6
`define DDRPI_CMD_NOP 3'h7

// ----------------------------------------------------------------
// Power state codes, one-hot
// ----------------------------------------------------------------
`define DDRPI_PWR_ACTIVE 4'h1
`define DDRPI_PWR_PD_PRE 4'h2
`define DDRPI_PWR_PD_ACT 4'h4
`define DDRPI_PWR_SELF_REF 4'h8

`endif

// ===== rtl/ddrpi_pkg.sv
`include "ddrpi_params.svh"

package ddrpi_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PWR_ACTIVE = `DDRPI_PWR_ACTIVE,
    PWR_PD_PRE = `DDRPI_PWR_PD_PRE,
    PWR_PD_ACT = `DDRPI_PWR_PD_ACT,
    PWR_SELF_REF = `DDRPI_PWR_SELF_REF
  } ddrpi_pwr_e;

  typedef enum logic [2:0] {
    CMD_LOAD_MODE = `DDRPI_CMD_LOAD_MODE,
    CMD_REFRESH = `DDRPI_CMD_REFRESH,
    CMD_PRECHARGE = `DDRPI_CMD_PRECHARGE,
    CMD_ACTIVATE = `DDRPI_CMD_ACTIVATE,
    CMD_WRITE = `DDRPI_CMD_WRITE,
    CMD_READ = `DDRPI_CMD_READ,
    CMD_BURST_STOP = `DDRPI_CMD_BURST_STOP,
    CMD_NOP = `DDRPI_CMD_NOP
  } ddrpi_cmd_e;

  // Deselect folds into no-operation so callers see one idle code
  function automatic ddrpi_cmd_e ddrpi_decode(input logic cs_n,
                                              input logic [2:0] strobes);
    ddrpi_cmd_e c;
    c = ddrpi_cmd_e'(strobes);
    if (cs_n)
    begin
      c = CMD_NOP;
    end
    return c;
  endfunction

endpackage

// ===== rtl/ddrpi_cmd_if.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Command path from the pin decoder to the bank tracker
// ----------------------------------------------------------------
interface ddrpi_cmd_if #(parameter int ADDR_W = 14);
  logic valid;
  ddrpi_pkg::ddrpi_cmd_e kind;
  logic [1:0] bank;
  logic [ADDR_W-1:0] addr;
  logic all_banks;
  logic [3:0] open_mask;
  logic [3:0][ADDR_W-1:0] rows;

  modport issue (output valid, output kind, output bank, output addr,
                 output all_banks, input open_mask, input rows);
  modport track (input valid, input kind, input bank, input addr,
                 input all_banks, output open_mask, output rows);
endinterface

// ===== rtl/ddrpi_sync.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ----------------------------------------------------------------
module ddrpi_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } ddrpi_sync_s;

  ddrpi_sync_s st;
  ddrpi_sync_s next_st;

  // First stage feeds only the second
  always_comb
  begin
    next_st.meta = d;
    next_st.sync = st.meta;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign q = st.sync;

endmodule

// ===== rtl/ddrpi_bank_table.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Open-row tracker for the four banks
// ----------------------------------------------------------------
module ddrpi_bank_table #(
  parameter int ADDR_W = 14
) (
  input wire logic clk,
  input wire logic resetn,
  ddrpi_cmd_if.track cmd
);

  typedef struct packed {
    logic [3:0] open;
    logic [3:0][ADDR_W-1:0] row;
  } ddrpi_bank_s;

  ddrpi_bank_s st;
  ddrpi_bank_s next_st;

  // Only activate, precharge and auto-precharge change bank state
  always_comb
  begin
    next_st = st;
    if (cmd.valid)
    begin
      case (cmd.kind)
        ddrpi_pkg::CMD_ACTIVATE:
        begin
          next_st.open[cmd.bank] = 1'b1; // RULE14
          next_st.row[cmd.bank] = cmd.addr; // RULE15
        end
        ddrpi_pkg::CMD_PRECHARGE:
        begin
          if (cmd.all_banks)
            next_st.open = 4'h0; // RULE16
          else
            next_st.open[cmd.bank] = 1'b0; // RULE16
        end
        ddrpi_pkg::CMD_READ, ddrpi_pkg::CMD_WRITE:
        begin
          // Closed at once; burst length is not tracked here
          if (cmd.all_banks)
            next_st.open[cmd.bank] = 1'b0; // RULE15
        end
        default:
          next_st = st; // RULE22
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign cmd.open_mask = st.open;
  assign cmd.rows = st.row;

endmodule

// ===== rtl/ddrpi_top.sv
// Summary of operation
// (RULE1) Sample inputs at true-rise, complement-fall crossing
// (RULE2) Clock gate high runs clock, buffers, drivers
// (RULE3) Gate low: idle power-down/self refresh, else active
// (RULE4) Gate registered on clock edge for power-down
// (RULE5) Self-refresh exit and driver disable are asynchronous
// (RULE6) Controller holds gate high during accesses
// (RULE7) Power-down keeps only clock and gate buffers
// (RULE8) Self refresh keeps only the gate buffer
// (RULE9) Chip select high masks every command
// (RULE10) Command from three strobes plus chip select
// (RULE11) Masked write beat is not stored
// (RULE12) Mask sampled on both strobe edges
// (RULE13) Lower mask covers lower byte, upper upper
// (RULE14) Bank selects pick the target bank
// (RULE15) Address gives row, column and auto-precharge bit
// (RULE16) Precharge scope bit picks one or all banks
// (RULE17) Mode load takes op-code from address
// (RULE18) Bank select 01 extended, 00 base register
// (RULE19) Read strobe edge-aligned; write strobe centred
// (RULE20) Two data words per link clock cycle
// (RULE21) Standard command truth table encoding
// (RULE22) Unknown or deselected cycles change nothing
`timescale 1ns/1ps
`include "ddrpi_params.svh"

module ddrpi_top #(
  parameter int ADDR_W = `DDRPI_ADDR_W
) (
  input wire logic clk,
  input wire logic resetn,
  // Link pins
  input wire logic true_clock_in,
  input wire logic complement_clock_in,
  input wire logic clock_gate,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_enable_n,
  input wire logic bank_select_0,
  input wire logic bank_select_1,
  input wire logic [ADDR_W-1:0] address,
  input wire logic lower_byte_mask,
  input wire logic upper_byte_mask,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe_n,
  input wire logic [1:0] data_strobe_in,
  output logic [1:0] data_strobe_out,
  output logic data_strobe_oe_n,
  // Core side: decoded commands
  output logic read_cmd,
  output logic write_cmd,
  output logic refresh_cmd,
  output logic burst_stop_cmd,
  output logic [1:0] cmd_bank,
  output logic [ADDR_W-1:0] cmd_address,
  output logic cmd_auto_precharge,
  output logic [ADDR_W-1:0] mode_base,
  output logic [ADDR_W-1:0] mode_extended,
  output logic mode_base_written,
  output logic mode_extended_written,
  output logic [3:0] bank_open,
  output logic [4*ADDR_W-1:0] bank_rows,
  // Core side: power state
  output logic [3:0] power_state,
  output logic internal_clock_on,
  output logic clock_buffers_on,
  output logic input_buffers_on,
  // Core side: write beats
  output logic write_beat_valid,
  output logic [15:0] write_beat_data,
  output logic [1:0] write_beat_keep,
  // Core side: read pairs
  input wire logic read_pair_valid,
  input wire logic [15:0] read_word_even,
  input wire logic [15:0] read_word_odd,
  output logic read_pair_ready
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  localparam int SW = ADDR_W + 29;

  generate
    if (ADDR_W < 11 || ADDR_W > 14)
    begin : g_bad_addr
      $error("ADDR_W must lie between 11 and 14");
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ddrpi_pkg::ddrpi_pwr_e pstate;
    logic tck_prev;
    logic [1:0] dqs_prev;
    logic tb_valid;
    ddrpi_pkg::ddrpi_cmd_e tb_kind;
    logic [1:0] tb_bank;
    logic [ADDR_W-1:0] tb_addr;
    logic tb_all;
    logic rd_cmd;
    logic wr_cmd;
    logic ref_cmd;
    logic stop_cmd;
    logic auto_pre;
    logic [1:0] c_bank;
    logic [ADDR_W-1:0] c_addr;
    logic [ADDR_W-1:0] m_base;
    logic [ADDR_W-1:0] m_ext;
    logic base_wr;
    logic ext_wr;
    logic beat_valid;
    logic [15:0] beat_data;
    logic [1:0] beat_keep;
    logic rd_pend;
    logic odd_due;
    logic rd_ready;
    logic [15:0] rd_even;
    logic [15:0] rd_odd;
    logic [15:0] d_out;
    logic [1:0] s_out;
    logic drive;
    logic [2:0] off_hist;
    logic int_clk_on;
    logic clk_buf_on;
    logic in_buf_on;
  } ddrpi_top_s;

  ddrpi_top_s st;
  ddrpi_top_s next_st;
  logic drive_off;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins;
  logic s_tck;
  logic s_cck;
  logic s_gate;
  logic s_cs_n;
  logic [2:0] s_strobes;
  logic [1:0] s_bank;
  logic [ADDR_W-1:0] s_addr;
  logic [1:0] s_mask;
  logic [15:0] s_data;
  logic [1:0] s_dqs;

  assign pins_raw = {true_clock_in, complement_clock_in, clock_gate,
                     chip_select_n, row_strobe_n, column_strobe_n,
                     write_enable_n, bank_select_1, bank_select_0,
                     address, upper_byte_mask, lower_byte_mask,
                     data_in, data_strobe_in};

  ddrpi_sync #(
    .W(SW)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d(pins_raw),
    .q(pins)
  );

  // All pins share one delay, so they stay aligned to the link edge
  assign {s_tck, s_cck, s_gate, s_cs_n, s_strobes, s_bank, s_addr,
          s_mask, s_data, s_dqs} = pins;

  // ----------------------------------------------------------------
  // Bank tracker
  // ----------------------------------------------------------------
  ddrpi_cmd_if #(
    .ADDR_W(ADDR_W)
  ) tb ();

  ddrpi_bank_table #(
    .ADDR_W(ADDR_W)
  ) u_banks (
    .clk(clk),
    .resetn(resetn),
    .cmd(tb)
  );

  assign tb.valid = st.tb_valid;
  assign tb.kind = st.tb_kind;
  assign tb.bank = st.tb_bank;
  assign tb.addr = st.tb_addr;
  assign tb.all_banks = st.tb_all;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic link_rise;
  logic link_fall;
  ddrpi_pkg::ddrpi_cmd_e cmd;
  logic [1:0] dqs_edge;

  // Crossing point: true clock rising while complement is low
  assign link_rise = s_tck && !st.tck_prev && !s_cck; // RULE1
  assign link_fall = !s_tck && st.tck_prev;
  assign cmd = ddrpi_pkg::ddrpi_decode(s_cs_n, s_strobes); // RULE10 RULE21
  assign dqs_edge = s_dqs ^ st.dqs_prev;

  always_comb
  begin
    next_st = st;
    next_st.tck_prev = s_tck;
    next_st.dqs_prev = s_dqs;
    next_st.off_hist = {st.off_hist[1:0], drive_off};
    next_st.tb_valid = 1'b0;
    next_st.rd_cmd = 1'b0;
    next_st.wr_cmd = 1'b0;
    next_st.ref_cmd = 1'b0;
    next_st.stop_cmd = 1'b0;
    next_st.base_wr = 1'b0;
    next_st.ext_wr = 1'b0;
    next_st.beat_valid = 1'b0;
    next_st.beat_keep = 2'h0;

    // Power state machine; gate is looked at on link rises, except in self refresh
    case (st.pstate)
      ddrpi_pkg::PWR_ACTIVE:
      begin
        if (link_rise && !s_gate) // RULE4
        begin
          if (cmd == ddrpi_pkg::CMD_REFRESH)
            next_st.pstate = ddrpi_pkg::PWR_SELF_REF; // RULE3
          else if (|tb.open_mask)
            next_st.pstate = ddrpi_pkg::PWR_PD_ACT; // RULE3
          else
            next_st.pstate = ddrpi_pkg::PWR_PD_PRE; // RULE3
        end
        else if (link_rise && s_gate)
        begin
          // Deselect decodes to no-operation and falls through
          next_st.tb_kind = cmd; // RULE9
          next_st.tb_bank = s_bank; // RULE14
          next_st.tb_addr = s_addr; // RULE15
          next_st.tb_all = s_addr[`DDRPI_SCOPE_BIT]; // RULE16
          case (cmd)
            ddrpi_pkg::CMD_ACTIVATE:
              next_st.tb_valid = 1'b1; // RULE14
            ddrpi_pkg::CMD_PRECHARGE:
              next_st.tb_valid = 1'b1; // RULE16
            ddrpi_pkg::CMD_READ, ddrpi_pkg::CMD_WRITE:
            begin
              next_st.tb_valid = 1'b1;
              next_st.rd_cmd = (cmd == ddrpi_pkg::CMD_READ);
              next_st.wr_cmd = (cmd == ddrpi_pkg::CMD_WRITE);
              next_st.c_bank = s_bank; // RULE14
              next_st.c_addr = s_addr; // RULE15
              next_st.auto_pre = s_addr[`DDRPI_SCOPE_BIT]; // RULE15
            end
            ddrpi_pkg::CMD_LOAD_MODE:
            begin
              // Other selector values write nothing
              if (s_bank == `DDRPI_MODE_SEL_BASE) // RULE18
              begin
                next_st.m_base = s_addr; // RULE17
                next_st.base_wr = 1'b1;
              end
              else if (s_bank == `DDRPI_MODE_SEL_EXT) // RULE18
              begin
                next_st.m_ext = s_addr; // RULE17
                next_st.ext_wr = 1'b1;
              end
            end
            ddrpi_pkg::CMD_REFRESH:
              next_st.ref_cmd = 1'b1;
            ddrpi_pkg::CMD_BURST_STOP:
              next_st.stop_cmd = 1'b1;
            default:
              next_st.tb_valid = 1'b0; // RULE22
          endcase
        end
      end
      ddrpi_pkg::PWR_PD_PRE, ddrpi_pkg::PWR_PD_ACT:
      begin
        // Commands are not decoded; only clock and gate are seen
        if (link_rise && s_gate) // RULE4 RULE7
          next_st.pstate = ddrpi_pkg::PWR_ACTIVE;
      end
      ddrpi_pkg::PWR_SELF_REF:
      begin
        // Link clock may be stopped, so no edge is awaited
        if (s_gate) // RULE5 RULE8
          next_st.pstate = ddrpi_pkg::PWR_ACTIVE;
      end
      default:
        next_st.pstate = ddrpi_pkg::PWR_ACTIVE;
    endcase

    // Buffer and clock status follow the state being entered
    next_st.int_clk_on =
      (next_st.pstate == ddrpi_pkg::PWR_ACTIVE); // RULE2
    next_st.in_buf_on =
      (next_st.pstate == ddrpi_pkg::PWR_ACTIVE); // RULE7
    next_st.clk_buf_on =
      (next_st.pstate != ddrpi_pkg::PWR_SELF_REF); // RULE8

    // Write capture on every strobe edge, per byte lane; held off
    // until the synchronised strobe no longer shows a read's drive
    if (st.in_buf_on && drive_off && &st.off_hist)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (dqs_edge[i]) // RULE12 RULE20
        begin
          next_st.beat_data[8*i +: 8] = s_data[8*i +: 8];
          next_st.beat_keep[i] = !s_mask[i]; // RULE11 RULE13
        end
      end
      next_st.beat_valid = |dqs_edge; // RULE19
    end

    // Read drive: even word on rise, odd word on fall
    if (!st.int_clk_on)
    begin
      next_st.drive = 1'b0; // RULE2
      next_st.odd_due = 1'b0;
    end
    else if (link_rise)
    begin
      next_st.drive = st.rd_pend;
      next_st.odd_due = st.rd_pend;
      if (st.rd_pend)
      begin
        next_st.d_out = st.rd_even; // RULE20
        next_st.s_out = 2'h3; // RULE19
        next_st.rd_odd = st.rd_odd;
      end
    end
    else if (link_fall && st.odd_due)
    begin
      next_st.d_out = st.rd_odd; // RULE20
      next_st.s_out = 2'h0; // RULE19
      next_st.odd_due = 1'b0;
    end

    // One pair buffered; taken again once its even word is on the pins
    next_st.rd_pend = st.rd_pend && !(link_rise && st.int_clk_on);
    if (read_pair_valid && st.rd_ready)
    begin
      next_st.rd_pend = 1'b1;
      next_st.rd_even = read_word_even;
      next_st.rd_odd = read_word_odd;
    end
    next_st.rd_ready = !next_st.rd_pend;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= '0;
      st.pstate <= ddrpi_pkg::PWR_ACTIVE;
      st.tb_kind <= ddrpi_pkg::CMD_NOP;
      st.rd_ready <= 1'b1;
      st.int_clk_on <= 1'b1;
      st.clk_buf_on <= 1'b1;
      st.in_buf_on <= 1'b1;
    end
    else
      st <= next_st;
  end

  // Kept apart from the main state: the gate pin must switch the
  // drivers off at once, before any synchroniser has seen it
  always_ff @(posedge clk or negedge resetn or negedge clock_gate)
  begin
    if (!resetn)
      drive_off <= 1'b1;
    else if (!clock_gate)
      drive_off <= 1'b1; // RULE5
    else
      drive_off <= !next_st.drive;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign data_out = st.d_out;
  assign data_oe_n = drive_off;
  assign data_strobe_out = st.s_out;
  assign data_strobe_oe_n = drive_off;
  assign read_cmd = st.rd_cmd;
  assign write_cmd = st.wr_cmd;
  assign refresh_cmd = st.ref_cmd;
  assign burst_stop_cmd = st.stop_cmd;
  assign cmd_bank = st.c_bank;
  assign cmd_address = st.c_addr;
  assign cmd_auto_precharge = st.auto_pre;
  assign mode_base = st.m_base;
  assign mode_extended = st.m_ext;
  assign mode_base_written = st.base_wr;
  assign mode_extended_written = st.ext_wr;
  assign bank_open = tb.open_mask;
  assign bank_rows = tb.rows;
  assign power_state = st.pstate;
  assign internal_clock_on = st.int_clk_on;
  assign clock_buffers_on = st.clk_buf_on;
  assign input_buffers_on = st.in_buf_on;
  assign write_beat_valid = st.beat_valid;
  assign write_beat_data = st.beat_data;
  assign write_beat_keep = st.beat_keep;
  assign read_pair_ready = st.rd_ready;

endmodule

// ===== dv/ddrpi_ctrl_model.sv
`timescale 1ns/1ps

// ------
// Controller model on the link pins
// ------
module ddrpi_ctrl_model (
  input wire logic clk,
  output logic tck,
  output logic clock_gate,
  output logic [3:0] cmd_n,
  output logic [1:0] bsel,
  output logic [13:0] address,
  output logic [1:0] mask,
  output logic [15:0] pdq,
  output logic [1:0] pdqs
);
  // Free-running link clock, phase unrelated to clk
  initial
  begin
    tck = 1'b0;
    clock_gate = 1'b1;
    cmd_n = 4'h7;
    bsel = 2'h0;
    address = 14'h0000;
    mask = 2'h0;
    pdq = 16'h0000;
    pdqs = 2'h0;
    #3;
    forever #32 tck = ~tck;
  end

  // Pins change mid link cycle so a rising crossing sees them settled
  task automatic issue(input logic g, input logic [3:0] c,
                       input logic [1:0] b, input logic [13:0] ad);
    @(negedge tck);
    @(posedge clk);
    clock_gate <= g;
    cmd_n <= c;
    bsel <= b;
    address <= ad;
    @(negedge tck);
    @(posedge clk);
    cmd_n <= 4'h7;
    @(negedge tck);
  endtask

  // Strobe moves two clocks into the beat; data is inverted six clocks later
  task automatic beat(input logic [1:0] t, input logic [1:0] m,
                      input logic [15:0] d);
    @(posedge clk);
    pdq <= d;
    mask <= m;
    repeat (2) @(posedge clk);
    pdqs <= pdqs ^ t;
    repeat (6) @(posedge clk);
    pdq <= ~d;
  endtask
endmodule

// ===== dv/ddrpi_top_asserts.sv
`timescale 1ns/1ps

module ddrpi_checker #(
  parameter int ADDR_W = 14
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clock_gate,
  input wire logic read_pair_valid,
  input wire logic read_pair_ready,
  input wire logic read_cmd,
  input wire logic write_cmd,
  input wire logic refresh_cmd,
  input wire logic [ADDR_W-1:0] mode_base,
  input wire logic mode_base_written,
  input wire logic [3:0] bank_open,
  input wire logic [3:0] power_state,
  input wire logic internal_clock_on,
  input wire logic clock_buffers_on,
  input wire logic input_buffers_on,
  input wire logic data_oe_n,
  input wire logic [15:0] data_out,
  input wire logic [1:0] data_strobe_out,
  input wire logic write_beat_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_active_runs: assert property (
    power_state == 4'h1 |-> internal_clock_on && input_buffers_on)
    else $error("active state with clock or buffers off");
  a_pd_buffers: assert property (
    power_state inside {4'h2, 4'h4} |->
      !input_buffers_on && clock_buffers_on && !internal_clock_on)
    else $error("power-down buffer state wrong");
  a_sr_buffers: assert property (
    power_state == 4'h8 |-> !input_buffers_on && !clock_buffers_on)
    else $error("self refresh buffer state wrong");
  a_gate_drivers: assert property (
    !clock_gate |-> data_oe_n)
    else $error("drivers on with clock gate low");
  a_sr_exit: assert property (
    power_state == 4'h8 && clock_gate |-> ##[1:6] power_state == 4'h1)
    else $error("self refresh not left");
  a_cmd_active: assert property (
    read_cmd || write_cmd || refresh_cmd |-> $past(power_state) == 4'h1)
    else $error("command outside active state");
  a_mode_hold: assert property (
    !mode_base_written |-> $stable(mode_base))
    else $error("base mode changed without load");
  a_open_hold: assert property (
    $changed(bank_open) |-> $past(power_state, 2) == 4'h1)
    else $error("bank state changed outside active");
  a_ready_drops: assert property (
    read_pair_valid && read_pair_ready |=> !read_pair_ready)
    else $error("read pair ready stayed high");
  a_edge_aligned: assert property (
    !data_oe_n && !$past(data_oe_n) && data_out != $past(data_out)
      |-> data_strobe_out != $past(data_strobe_out))
    else $error("read data moved without strobe");

  c_read: cover property (read_cmd);
  c_self_ref: cover property (power_state == 4'h8);
  c_beat: cover property (write_beat_valid);
  c_drive: cover property (!data_oe_n);
endmodule

bind ddrpi_top ddrpi_checker #(.ADDR_W(ADDR_W)) i_ddrpi_checker (
  .clk, .resetn, .clock_gate, .read_pair_valid, .read_pair_ready,
  .read_cmd, .write_cmd, .refresh_cmd, .mode_base, .mode_base_written,
  .bank_open, .power_state, .internal_clock_on, .clock_buffers_on,
  .input_buffers_on, .data_oe_n, .data_out, .data_strobe_out,
  .write_beat_valid
);

// ===== dv/testbench.sv
`timescale 1ns/1ps

module testbench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic tck, clock_gate, data_oe_n, data_strobe_oe_n;
  logic [3:0] cmd_n, bank_open, power_state;
  logic [1:0] bsel, mask, pdqs, data_strobe_out, cmd_bank;
  logic [13:0] address, cmd_address, mode_base, mode_extended;
  logic [15:0] pdq, data_out, write_beat_data, bdata;
  logic [55:0] bank_rows;
  logic read_cmd, write_cmd, refresh_cmd, burst_stop_cmd;
  logic cmd_auto_precharge, clock_buffers_on, input_buffers_on;
  logic write_beat_valid, read_pair_ready, ext_wr;
  logic [1:0] write_beat_keep, bkeep;
  logic read_pair_valid = 1'b0;
  logic [15:0] read_word_even = 16'h0000;
  logic [15:0] read_word_odd = 16'h0000;
  int n_rd = 0, n_wr = 0, n_rf = 0, n_bs = 0, n_bt = 0, n_me = 0;
  int failures = 0, check_count = 0, i;

  // ------
  // Clock, wires, instances
  // ------
  always #4 clk = ~clk;

  ddrpi_ctrl_model ctl (.clk, .tck, .clock_gate, .cmd_n, .bsel,
    .address, .mask, .pdq, .pdqs);

  ddrpi_top i_ddrpi_top (.clk, .resetn, .true_clock_in(tck),
    .complement_clock_in(~tck), .clock_gate,
    .chip_select_n(cmd_n[3]), .row_strobe_n(cmd_n[2]),
    .column_strobe_n(cmd_n[1]), .write_enable_n(cmd_n[0]),
    .bank_select_0(bsel[0]), .bank_select_1(bsel[1]), .address,
    .lower_byte_mask(mask[0]), .upper_byte_mask(mask[1]),
    .data_in(data_oe_n ? pdq : data_out), .data_out, .data_oe_n,
    .data_strobe_in(data_strobe_oe_n ? pdqs : data_strobe_out),
    .data_strobe_out, .data_strobe_oe_n, .read_cmd, .write_cmd,
    .refresh_cmd, .burst_stop_cmd, .cmd_bank, .cmd_address,
    .cmd_auto_precharge, .mode_base, .mode_extended,
    .mode_base_written(), .mode_extended_written(ext_wr), .bank_open,
    .bank_rows, .power_state, .internal_clock_on(), .clock_buffers_on,
    .input_buffers_on, .write_beat_valid, .write_beat_data,
    .write_beat_keep, .read_pair_valid, .read_word_even, .read_word_odd,
    .read_pair_ready);

  // Pulses are too short to poll, so tally them here
  always @(posedge clk)
  begin
    n_rd <= n_rd + int'(read_cmd);
    n_wr <= n_wr + int'(write_cmd);
    n_rf <= n_rf + int'(refresh_cmd);
    n_bs <= n_bs + int'(burst_stop_cmd);
    n_bt <= n_bt + int'(write_beat_valid);
    n_me <= n_me + int'(ext_wr);
    if (write_beat_valid)
    begin
      bkeep <= write_beat_keep;
      bdata <= write_beat_data;
    end
  end

  // ------
  // Checking and verdict
  // ------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Sequence of command, beat and read tests
  initial
  begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    check(power_state, 4'h1);
    ctl.issue(1, 4'h0, 2'h1, 14'h0123);
    ctl.issue(1, 4'h0, 2'h0, 14'h0456);
    ctl.issue(1, 4'h0, 2'h2, 14'h3FFF);
    check({n_me, mode_extended}, {32'd1, 14'h0123});
    check(mode_base, 14'h0456);
    ctl.issue(1, 4'hB, 2'h0, 14'h0111);
    check(bank_open, 4'h0);
    for (i = 0; i < 4; i++)
      ctl.issue(1, 4'h3, i[1:0], 14'h0100 + 14'(i));
    check(bank_open, 4'hF);
    for (i = 0; i < 4; i++)
      check(bank_rows[i*14 +: 14], 14'h0100 + 14'(i));
    ctl.issue(1, 4'h4, 2'h2, 14'h040C);
    check({n_wr, cmd_bank, cmd_address}, {32'd1, 2'h2, 14'h040C});
    check({cmd_auto_precharge, bank_open}, {1'b1, 4'hB});
    ctl.issue(1, 4'h5, 2'h1, 14'h0008);
    check({n_rd, cmd_bank, cmd_auto_precharge}, {32'd1, 3'h2});
    ctl.issue(1, 4'h2, 2'h0, 14'h0000);
    check(bank_open, 4'hA);
    ctl.issue(1, 4'h1, 2'h0, 14'h0000);
    ctl.issue(1, 4'h6, 2'h0, 14'h0000);
    check({n_rf, n_bs}, {32'd1, 32'd1});
    ctl.issue(1, 4'h2, 2'h3, 14'h0400);
    check(bank_open, 4'h0);
    ctl.beat(2'h3, 2'h1, 16'hA55A);
    check({n_bt, bkeep, bdata}, {32'd1, 2'h2, 16'hA55A});
    ctl.beat(2'h1, 2'h0, 16'h1234);
    check({n_bt, bkeep, bdata}, {32'd2, 2'h1, 16'hA534});
    @(posedge clk);
    read_pair_valid <= 1'b1;
    read_word_even <= 16'hC001;
    read_word_odd <= 16'h0DD5;
    @(posedge clk);
    read_pair_valid <= 1'b0;
    @(negedge clk);
    while (data_oe_n !== 1'b0) @(negedge clk);
    check({data_out, data_strobe_out}, {16'hC001, 2'h3});
    while (data_strobe_out !== 2'h0) @(negedge clk);
    check({data_out, data_strobe_oe_n}, {16'h0DD5, 1'b0});
    ctl.issue(1, 4'h3, 2'h0, 14'h0007);
    check(n_bt, 32'd2);
    ctl.issue(0, 4'h7, 2'h0, 14'h0000);
    check({power_state, data_oe_n}, {4'h4, 1'b1});
    ctl.issue(0, 4'h2, 2'h0, 14'h0400);
    check(bank_open, 4'h1);
    ctl.issue(1, 4'h7, 2'h0, 14'h0000);
    check(power_state, 4'h1);
    ctl.issue(1, 4'h2, 2'h0, 14'h0400);
    ctl.issue(0, 4'h7, 2'h0, 14'h0000);
    check({power_state, input_buffers_on}, {4'h2, 1'b0});
    ctl.issue(1, 4'h7, 2'h0, 14'h0000);
    ctl.issue(0, 4'h1, 2'h0, 14'h0000);
    check({power_state, clock_buffers_on}, {4'h8, 1'b0});
    @(posedge clk);
    ctl.clock_gate <= 1'b1;
    repeat (6) @(posedge clk);
    check(power_state, 4'h1);
    give_verdict;
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (8000) @(posedge clk);
    failures++;
    give_verdict;
  end
endmodule
